// ===== dv/pkn_navigator_tb.sv
`timescale 1ns/10ps
`include "pkn_consts.svh"

module pkn_navigator_tb;
  localparam int LONG = 20;
  localparam int SH = 3;
  localparam int LG = LONG + 4;
  logic i_clk_sys, i_rst, i_cfg_defaults, i_bus_active;
  logic i_bus_timeout, i_bus_exception, i_bus_err_clear;
  logic k_up, k_down, k_set;
  logic [3:0] i_win_count, i_win_last, o_win_num, o_max_elem, w;
  logic [15:0] i_auto_interval_s, o_auto_interval_s;
  logic [31:0] i_chan_err, o_diag_mark;
  logic o_auto, o_bus_err, o_diag_refresh;
  pkn_pkg::pkn_mode_e o_mode;
  pkn_pkg::pkn_footer_s o_footer;
  int errors = 0;
  int total_checks = 0;

  pkn_operator op (.i_clk_sys(i_clk_sys), .o_key_up(k_up),
    .o_key_down(k_down), .o_key_set(k_set));

  pkn_navigator #(.LONG_CYC(LONG), .MS_CYC(2), .REFRESH_CYC(50),
    .NUM_CHAN(32)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_key_up(k_up),
    .i_key_down(k_down), .i_key_set(k_set), .i_win_count(i_win_count),
    .i_win_last(i_win_last), .i_auto_interval_s(i_auto_interval_s),
    .i_cfg_defaults(i_cfg_defaults), .i_bus_active(i_bus_active),
    .i_bus_timeout(i_bus_timeout), .i_bus_exception(i_bus_exception),
    .i_chan_err(i_chan_err), .i_bus_err_clear(i_bus_err_clear),
    .o_mode(o_mode), .o_win_num(o_win_num), .o_max_elem(o_max_elem),
    .o_auto(o_auto), .o_footer(o_footer), .o_bus_err(o_bus_err),
    .o_diag_mark(o_diag_mark), .o_diag_refresh(o_diag_refresh),
    .o_auto_interval_s(o_auto_interval_s));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One-cycle pulse on an input
  task automatic pulse(input int sel);
    @(posedge i_clk_sys);
    case (sel)
      0: i_cfg_defaults <= 1'b1;
      1: i_bus_timeout <= 1'b1;
      2: i_bus_exception <= 1'b1;
      default: i_bus_err_clear <= 1'b1;
    endcase
    @(posedge i_clk_sys);
    i_cfg_defaults <= 1'b0;
    i_bus_timeout <= 1'b0;
    i_bus_exception <= 1'b0;
    i_bus_err_clear <= 1'b0;
    #1;
  endtask

  function automatic logic [3:0] nxt(input logic [3:0] v);
    return (v == 4'h4) ? 4'h1 : v + 4'h1;
  endfunction

  initial begin
    i_rst = 1'b1;
    i_win_count = 4'h4;
    i_win_last = 4'h2;
    i_auto_interval_s = 16'h0;
    i_cfg_defaults = 1'b0;
    i_bus_active = 1'b0;
    i_bus_timeout = 1'b0;
    i_bus_exception = 1'b0;
    i_bus_err_clear = 1'b0;
    i_chan_err = 32'h0;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk("mode", 32'(o_mode), 32'(pkn_pkg::PKN_ST_NORMAL));
    chk("auto", 32'(o_auto), 32'h0);
    chk("interval", 32'(o_auto_interval_s), 32'h5);
    chk("footer", 32'(o_footer), 32'h0);
    chk("max_elem", 32'(o_max_elem), 32'hc);
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk("win restore", 32'(o_win_num), 32'h3);
    $display("test reset done");

    op.press(3'h2, SH);
    chk("win down", 32'(o_win_num), 32'h4);
    op.press(3'h2, SH);
    chk("win wrap", 32'(o_win_num), 32'h1);
    op.press(3'h1, SH);
    chk("win up wrap", 32'(o_win_num), 32'h4);
    op.press(3'h3, SH);
    chk("two keys", 32'(o_win_num), 32'h4);
    op.press(3'h3, LG);
    chk("two keys long", 32'(o_auto), 32'h0);
    op.press(3'h5, LG);
    chk("two keys mode", 32'(o_mode), 32'(pkn_pkg::PKN_ST_NORMAL));
    $display("test navigation done");

    op.press(3'h4, LG);
    chk("enter cfg", 32'(o_mode), 32'(pkn_pkg::PKN_ST_CONFIG));
    op.press(3'h2, SH);
    chk("cfg nav", 32'(o_win_num), 32'h4);
    op.press(3'h4, LG);
    chk("leave cfg", 32'(o_mode), 32'(pkn_pkg::PKN_ST_NORMAL));
    $display("test config done");

    @(posedge i_clk_sys);
    i_auto_interval_s <= 16'h1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk("interval set", 32'(o_auto_interval_s), 32'h1);
    op.press(3'h1, LG);
    chk("auto on", 32'(o_auto), 32'h1);
    chk("auto footer", 32'(o_footer.autoscroll),
        32'(`PKN_COL_YELLOW));
    w = o_win_num;
    for (int i = 0; i < 2100 && o_win_num === w; i++) begin
      @(posedge i_clk_sys);
      #1;
    end
    chk("auto step", 32'(o_win_num), 32'(nxt(w)));
    op.press(3'h2, LG);
    chk("auto off", 32'(o_auto), 32'h0);
    chk("auto off footer", 32'(o_footer.autoscroll),
        32'(`PKN_COL_BLACK));
    @(posedge i_clk_sys);
    i_auto_interval_s <= 16'h0;
    pulse(0);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("interval dflt", 32'(o_auto_interval_s), 32'h5);
    $display("test autoscroll done");

    op.press(3'h4, SH);
    chk("diag refused", 32'(o_mode), 32'(pkn_pkg::PKN_ST_NORMAL));
    pulse(1);
    chk("timeout err", 32'(o_bus_err), 32'h1);
    chk("link red", 32'(o_footer.bus_link_status_indicator),
        32'(`PKN_COL_RED));
    w = o_win_num;
    op.press(3'h2, SH);
    chk("nav in err", 32'(o_win_num), 32'(nxt(w)));
    @(posedge i_clk_sys);
    i_chan_err <= 32'h20;
    op.press(3'h4, SH);
    chk("diag on", 32'(o_mode), 32'(pkn_pkg::PKN_ST_DIAG));
    chk("marks", o_diag_mark, 32'h20);
    @(posedge i_clk_sys);
    i_chan_err <= 32'h60;
    for (int i = 0; i < 60 && o_diag_refresh !== 1'b1; i++) begin
      @(posedge i_clk_sys);
      #1;
    end
    chk("refresh", 32'(o_diag_refresh), 32'h1);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("marks upd", o_diag_mark, 32'h60);
    op.press(3'h4, SH);
    chk("diag off", 32'(o_mode), 32'(pkn_pkg::PKN_ST_NORMAL));
    @(posedge i_clk_sys);
    i_chan_err <= 32'h0;
    i_bus_active <= 1'b1;
    pulse(3);
    chk("err clear", 32'(o_bus_err), 32'h0);
    chk("link green", 32'(o_footer.bus_link_status_indicator),
        32'(`PKN_COL_GREEN));
    pulse(2);
    chk("exc err", 32'(o_bus_err), 32'h1);
    chk("exc red", 32'(o_footer.bus_link_status_indicator),
        32'(`PKN_COL_RED));
    $display("test bus done");
    stop_test();
  end
endmodule // pkn_navigator_tb

// ===== dv/pkn_operator.sv
`timescale 1ns/10ps

module pkn_operator (
  // Clock
  input wire logic i_clk_sys,
  // Key levels, high while pressed
  output logic o_key_up,
  output logic o_key_down,
  output logic o_key_set
);
  initial begin
    o_key_up = 1'b0;
    o_key_down = 1'b0;
    o_key_set = 1'b0;
  end

  // One gesture: keys in mask {set,down,up} held, then all released
  task automatic press(input logic [2:0] mask, input int hold);
    @(posedge i_clk_sys);
    {o_key_set, o_key_down, o_key_up} <= mask;
    repeat (hold) @(posedge i_clk_sys);
    {o_key_set, o_key_down, o_key_up} <= 3'h0;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
endmodule // pkn_operator

// ===== verilog/pkn_consts.svh
`ifndef PKN_CONSTS_SVH
`define PKN_CONSTS_SVH

// Clock rate and derived counts
`define PKN_CLK_HZ 200000000
`define PKN_LONG_PRESS_MS 2000
`define PKN_LONG_PRESS_CYC ((`PKN_CLK_HZ / 1000) * `PKN_LONG_PRESS_MS)
`define PKN_AUTO_DEF_S 5
`define PKN_DIAG_REFRESH_MS 1000
`define PKN_DIAG_REFRESH_CYC ((`PKN_CLK_HZ / 1000) * `PKN_DIAG_REFRESH_MS)
`define PKN_MS_CYC (`PKN_CLK_HZ / 1000)

// Window and channel limits
`define PKN_MAX_WIN 10
`define PKN_MAX_ELEM 12
`define PKN_NUM_CHAN 32

// Reset values
`define PKN_WIN_RST 4'h0

// Footer colour codes
`define PKN_COL_BLACK 2'h0
`define PKN_COL_GREEN 2'h1
`define PKN_COL_RED 2'h2
`define PKN_COL_YELLOW 2'h3

`endif

// ===== verilog/pkn_key_sorter.sv
`timescale 1ns/10ps
`include "pkn_consts.svh"

module pkn_key_sorter #(
  parameter int unsigned LONG_CYC = `PKN_LONG_PRESS_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // One key level, high while pressed
  input wire logic i_key,
  // Release events and key-held flag
  output logic o_short,
  output logic o_long,
  output logic o_busy
);

  logic [31:0] hold_q;
  logic key_q;
  logic is_long_q;
  logic short_q;
  logic long_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      key_q <= 1'b0;
    end else begin
      key_q <= i_key;
    end
  end

  // Hold counter saturates at the long threshold
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hold_q <= 32'h0;
      is_long_q <= 1'b0;
    end else if (!i_key) begin
      hold_q <= 32'h0;
      is_long_q <= 1'b0;
    end else if (hold_q >= LONG_CYC - 1) begin
      is_long_q <= 1'b1;
    end else begin
      hold_q <= hold_q + 32'h1;
    end
  end

  // Classify on release
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      short_q <= 1'b0;
      long_q <= 1'b0;
    end else begin
      short_q <= key_q && !i_key && !is_long_q;
      long_q <= key_q && !i_key && is_long_q;
    end
  end

  assign o_short = short_q;
  assign o_long = long_q;
  assign o_busy = key_q;

endmodule // pkn_key_sorter

// ===== verilog/pkn_navigator.sv
// Operation
// - Hold past two seconds is long press
// - Simultaneous keys give no action
// - Reset starts normal on last window
// - Long set toggles configuration menu
// - Short up/down steps previous/next window
// - At most ten windows, twelve elements
// - Header shows window number in brackets
// - Long up/down starts automatic stepping
// - Another long up/down stops stepping
// - Footer shows autoscroll yellow while stepping
// - Step interval configurable, five seconds default
// - Bus error turns link indicator red
// - Timeout or exception counts as error
// - Bus error never blocks navigation
// - Short set opens channel diagnostic table
// - Table opens only under bus error
// - Faulty channels carry error marker
// - Table refreshes once every second
// - Footer colours black/green/red/yellow
`timescale 1ns/10ps
`include "pkn_consts.svh"

module pkn_navigator #(
  parameter int unsigned LONG_CYC = `PKN_LONG_PRESS_CYC,
  parameter int unsigned MS_CYC = `PKN_MS_CYC,
  parameter int unsigned REFRESH_CYC = `PKN_DIAG_REFRESH_CYC,
  parameter int unsigned NUM_CHAN = `PKN_NUM_CHAN
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Keys, high while pressed
  input wire logic i_key_up,
  input wire logic i_key_down,
  input wire logic i_key_set,
  // Window configuration
  input wire logic [3:0] i_win_count,
  input wire logic [3:0] i_win_last,
  input wire logic [15:0] i_auto_interval_s,
  input wire logic i_cfg_defaults,
  // Bus monitoring
  input wire logic i_bus_active,
  input wire logic i_bus_timeout,
  input wire logic i_bus_exception,
  input wire logic [NUM_CHAN-1:0] i_chan_err,
  input wire logic i_bus_err_clear,
  // Display state
  output pkn_pkg::pkn_mode_e o_mode,
  output logic [3:0] o_win_num,
  output logic [3:0] o_max_elem,
  output logic o_auto,
  output pkn_pkg::pkn_footer_s o_footer,
  output logic o_bus_err,
  output logic [NUM_CHAN-1:0] o_diag_mark,
  output logic o_diag_refresh,
  output logic [15:0] o_auto_interval_s
);

  localparam logic [3:0] MAX_WIN = 4'(`PKN_MAX_WIN);

  logic [2:0] k_short;
  logic [2:0] k_long;
  logic [2:0] k_busy;
  logic [2:0] k_lvl;
  logic multi_q;
  pkn_pkg::pkn_key_evt_s evt;
  pkn_pkg::pkn_mode_e mode_q;
  logic [3:0] win_q;
  logic [3:0] win_cnt;
  logic auto_q;
  logic bus_err_q;
  logic [NUM_CHAN-1:0] mark_q;
  logic [15:0] ival_q;
  logic [31:0] ms_q;
  logic [15:0] sec_q;
  logic [31:0] ref_q;
  logic refresh_q;
  logic restore_q;
  logic step_tick;
  logic ev_up_s;
  logic ev_dn_s;
  logic ev_set_s;
  logic ev_up_l;
  logic ev_dn_l;
  logic ev_set_l;
  logic [3:0] win_next;
  logic [3:0] win_prev;

  assign k_lvl = {i_key_set, i_key_down, i_key_up};

  // One sorter per key
  genvar gk;
  generate
    for (gk = 0; gk < 3; gk++) begin : g_key
      pkn_key_sorter #(
        .LONG_CYC(LONG_CYC)
      ) u_sort (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_key(k_lvl[gk]),
        .o_short(k_short[gk]),
        .o_long(k_long[gk]),
        .o_busy(k_busy[gk])
      );
    end
  endgenerate

  // Any overlap of two keys taints the gesture
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      multi_q <= 1'b0;
    end else if (k_busy == 3'h0 && k_lvl == 3'h0) begin
      multi_q <= 1'b0;
    end else if ($countones(k_lvl) > 1 || $countones(k_busy) > 1) begin
      multi_q <= 1'b1;
    end
  end

  // Single key event, suppressed when tainted
  always_comb begin
    evt = '0;
    if (!multi_q && $countones(k_lvl) < 2) begin
      if (k_short[0] || k_long[0]) begin
        evt.valid = 1'b1;
        evt.key = pkn_pkg::PKN_KEY_UP;
        evt.long_press = k_long[0];
      end else if (k_short[1] || k_long[1]) begin
        evt.valid = 1'b1;
        evt.key = pkn_pkg::PKN_KEY_DOWN;
        evt.long_press = k_long[1];
      end else if (k_short[2] || k_long[2]) begin
        evt.valid = 1'b1;
        evt.key = pkn_pkg::PKN_KEY_SET;
        evt.long_press = k_long[2];
      end
    end
  end

  // Six distinct events
  assign ev_up_s = evt.valid && evt.key == pkn_pkg::PKN_KEY_UP &&
                   !evt.long_press;
  assign ev_dn_s = evt.valid && evt.key == pkn_pkg::PKN_KEY_DOWN &&
                   !evt.long_press;
  assign ev_set_s = evt.valid && evt.key == pkn_pkg::PKN_KEY_SET &&
                    !evt.long_press;
  assign ev_up_l = evt.valid && evt.key == pkn_pkg::PKN_KEY_UP &&
                   evt.long_press;
  assign ev_dn_l = evt.valid && evt.key == pkn_pkg::PKN_KEY_DOWN &&
                   evt.long_press;
  assign ev_set_l = evt.valid && evt.key == pkn_pkg::PKN_KEY_SET &&
                    evt.long_press;

  // Clamp window count to ten, at least one
  assign win_cnt = (i_win_count == 4'h0) ? 4'h1 :
                   (i_win_count > MAX_WIN) ? MAX_WIN : i_win_count;
  // Wrap at both ends
  assign win_next = (win_q + 4'h1 >= win_cnt) ? 4'h0 : win_q + 4'h1;
  assign win_prev = (win_q == 4'h0 || win_q >= win_cnt) ?
                    win_cnt - 4'h1 : win_q - 4'h1;

  // Mode machine
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode_q <= pkn_pkg::PKN_ST_NORMAL;
    end else begin
      case (mode_q)
        pkn_pkg::PKN_ST_NORMAL: begin
          if (ev_set_l) begin
            mode_q <= pkn_pkg::PKN_ST_CONFIG;
          end else if (ev_set_s && bus_err_q) begin
            mode_q <= pkn_pkg::PKN_ST_DIAG;
          end
        end
        pkn_pkg::PKN_ST_CONFIG: begin
          if (ev_set_l) begin
            mode_q <= pkn_pkg::PKN_ST_NORMAL;
          end
        end
        pkn_pkg::PKN_ST_DIAG: begin
          if (ev_set_s || ev_set_l) begin
            mode_q <= pkn_pkg::PKN_ST_NORMAL;
          end
        end
        default: begin
          mode_q <= pkn_pkg::PKN_ST_NORMAL;
        end
      endcase
    end
  end

  // Auto stepping toggle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      auto_q <= 1'b0;
    end else if (mode_q != pkn_pkg::PKN_ST_NORMAL) begin
      auto_q <= 1'b0;
    end else if (ev_up_l || ev_dn_l) begin
      auto_q <= !auto_q;
    end
  end

  // Step interval, default five seconds
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_cfg_defaults) begin
      ival_q <= 16'(`PKN_AUTO_DEF_S);
    end else if (i_auto_interval_s != 16'h0) begin
      ival_q <= i_auto_interval_s;
    end
  end

  // Seconds timer for auto stepping
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !auto_q) begin
      ms_q <= 32'h0;
      sec_q <= 16'h0;
    end else if (ms_q >= 1000 * MS_CYC - 1) begin
      ms_q <= 32'h0;
      sec_q <= step_tick ? 16'h0 : sec_q + 16'h1;
    end else begin
      ms_q <= ms_q + 32'h1;
    end
  end

  assign step_tick = auto_q && ms_q >= 1000 * MS_CYC - 1 &&
                     sec_q + 16'h1 >= ival_q;
  always_ff @(posedge i_clk_sys) begin
    restore_q <= i_rst;
  end

  // Window selection, works regardless of bus errors
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      win_q <= `PKN_WIN_RST;
    end else if (restore_q && i_win_last < win_cnt) begin
      win_q <= i_win_last;
    end else if (mode_q == pkn_pkg::PKN_ST_NORMAL) begin
      if (!auto_q && ev_up_s) begin
        win_q <= win_prev;
      end else if (!auto_q && ev_dn_s) begin
        win_q <= win_next;
      end else if (step_tick) begin
        win_q <= win_next;
      end else if (win_q >= win_cnt) begin
        win_q <= win_cnt - 4'h1;
      end
    end
  end

  // Bus error flag, set wins over clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bus_err_q <= 1'b0;
    end else if (i_bus_timeout || i_bus_exception || |i_chan_err) begin
      bus_err_q <= 1'b1;
    end else if (i_bus_err_clear) begin
      bus_err_q <= 1'b0;
    end
  end

  // Once per second snapshot while diag shown
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || mode_q != pkn_pkg::PKN_ST_DIAG) begin
      ref_q <= 32'h0;
      refresh_q <= 1'b0;
    end else if (ref_q >= REFRESH_CYC - 1) begin
      ref_q <= 32'h0;
      refresh_q <= 1'b1;
    end else begin
      ref_q <= ref_q + 32'h1;
      refresh_q <= 1'b0;
    end
  end

  // Per-channel error markers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mark_q <= '0;
    end else if (mode_q == pkn_pkg::PKN_ST_NORMAL && ev_set_s &&
                 bus_err_q) begin
      mark_q <= i_chan_err;
    end else if (refresh_q) begin
      mark_q <= i_chan_err;
    end
  end

  // Footer colours
  always_comb begin
    o_footer.bus_link_status_indicator = bus_err_q ? `PKN_COL_RED :
      (i_bus_active ? `PKN_COL_GREEN : `PKN_COL_BLACK);
    o_footer.autoscroll = auto_q ? `PKN_COL_YELLOW :
                                   `PKN_COL_BLACK;
  end

  assign o_mode = mode_q;
  assign o_win_num = win_q + 4'h1;
  assign o_max_elem = 4'(`PKN_MAX_ELEM);
  assign o_auto = auto_q;
  assign o_bus_err = bus_err_q;
  assign o_diag_mark = mark_q;
  assign o_diag_refresh = refresh_q;
  assign o_auto_interval_s = ival_q;

  // Checks
  sequence s_auto_on;
    !auto_q ##1 auto_q;
  endsequence

  property p_long_set_cfg;
    @(posedge i_clk_sys) disable iff (i_rst)
    (mode_q == pkn_pkg::PKN_ST_NORMAL && ev_set_l) |=>
      mode_q == pkn_pkg::PKN_ST_CONFIG;
  endproperty
  a_long_set_cfg: assert property (p_long_set_cfg)
    else $error("long set did not enter config");

  property p_diag_gate;
    @(posedge i_clk_sys) disable iff (i_rst)
    (mode_q == pkn_pkg::PKN_ST_NORMAL && ev_set_s && !bus_err_q) |=>
      mode_q == pkn_pkg::PKN_ST_NORMAL;
  endproperty
  a_diag_gate: assert property (p_diag_gate)
    else $error("diag opened without bus error");

  property p_err_red;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_bus_timeout || i_bus_exception) |=>
      o_footer.bus_link_status_indicator == `PKN_COL_RED;
  endproperty
  a_err_red: assert property (p_err_red)
    else $error("bus error not shown red");

  property p_auto_yellow;
    @(posedge i_clk_sys) disable iff (i_rst)
    s_auto_on |-> o_footer.autoscroll == `PKN_COL_YELLOW;
  endproperty
  a_auto_yellow: assert property (p_auto_yellow)
    else $error("autoscroll not yellow");

  property p_auto_start;
    @(posedge i_clk_sys) disable iff (i_rst)
    (mode_q == pkn_pkg::PKN_ST_NORMAL && !auto_q && ev_up_l) |=> auto_q;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("long up did not start stepping");

  property p_auto_stop;
    @(posedge i_clk_sys) disable iff (i_rst)
    (mode_q == pkn_pkg::PKN_ST_NORMAL && auto_q && ev_dn_l) |=> !auto_q;
  endproperty
  a_auto_stop: assert property (p_auto_stop)
    else $error("long down did not stop stepping");

  property p_win_range;
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 (o_win_num >= 4'h1 && o_win_num <= MAX_WIN);
  endproperty
  a_win_range: assert property (p_win_range)
    else $error("window number out of range");

  property p_wrap;
    @(posedge i_clk_sys) disable iff (i_rst)
    (mode_q == pkn_pkg::PKN_ST_NORMAL && !auto_q && ev_dn_s &&
     win_q == win_cnt - 4'h1) |=> win_q == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("window did not wrap");

endmodule // pkn_navigator

// ===== verilog/pkn_pkg.sv
package pkn_pkg;

  typedef enum logic [1:0] {
    PKN_ST_NORMAL = 2'b00,
    PKN_ST_CONFIG = 2'b01,
    PKN_ST_DIAG = 2'b10
  } pkn_mode_e;

  typedef enum logic [1:0] {
    PKN_KEY_UP = 2'b00,
    PKN_KEY_DOWN = 2'b01,
    PKN_KEY_SET = 2'b10
  } pkn_key_e;

  typedef struct packed {
    logic valid;
    logic long_press;
    pkn_key_e key;
  } pkn_key_evt_s;

  typedef struct packed {
    logic [1:0] autoscroll;
    logic [1:0] bus_link_status_indicator;
  } pkn_footer_s;

endpackage
